//--- core/bcd_bus_command_decoder.sv
// Chosen here: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "bcd_defines.svh"
// Contract
// RL1 - Command register is write-only; reading it gives no meaningful data.
// RL2 - Upper five bits are reserved; writing them changes nothing.
// RL3 - Executing flag is set while a command runs, cleared on entering result.
// RL4 - Code 000 is a no-operation.
// RL5 - Codes 100 and 111 are undefined and do nothing.
// RL6 - Code 001 releases the lock set up by another unit.
// RL7 - Unlock is ignored during slave communication.
// RL8 - Code 010 requests communication as bus master.
// RL9 - Code 011 acts only while master request pending or master running.
// RL10 - Accepted master stop enters wait and clears master request.
// RL11 - Code 101 requests a slave data transfer to the master.
// RL12 - Code 110 acts only while slave request flag is one.
// RL13 - Slave stop before transmission clears request; later master request unanswered.
// RL14 - Slave stop during transmission aborts it, enters wait, clears request.
// RL15 - Each command write gives a one-cycle strobe; field returns to no-operation.
module bcd_bus_command_decoder
   import bcd_pkg::*;
#(
   parameter int unsigned EXEC_CYCLES = `BCD_EXEC_CYCLES,
   parameter int unsigned STOP_CYCLES = `BCD_STOP_CYCLES
) (
   input  wire logic                   sys_clk,
   input  wire logic                   arst_n,
   input  wire logic [`BCD_ADDR_W-1:0] regAddr,
   input  wire logic [`BCD_DATA_W-1:0] regWdata,
   input  wire logic                   regWr,
   input  wire logic                   regRd,
   output logic      [`BCD_DATA_W-1:0] regRdata,
   input  wire logic                   lockSet,
   input  wire logic                   masterStart,
   input  wire logic                   masterEnd,
   input  wire logic                   slaveSelect,
   input  wire logic                   slaveTxReq,
   input  wire logic                   slaveEnd,
   output logic                        cmdStrobe,
   output logic      [2:0]             cmdCode,
   output logic                        cmdExecuting,
   output logic                        masterRequest,
   output logic                        slaveRequest,
   output logic                        lockActive,
   output logic                        slaveAbort,
   output logic                        slaveRespond,
   output logic      [1:0]             busState
);

   // ****************************************
   // Declarations
   // ****************************************
   bcd_exec_if ex ();

   bcd_state_t             state;
   bcd_state_t             next_state;
   bcd_code_t              cmdField;
   bcd_code_t              next_cmdField;
   logic                   next_cmdStrobe;
   logic                   next_cmdExecuting;
   logic                   next_masterRequest;
   logic                   next_slaveRequest;
   logic                   next_lockActive;
   logic                   next_slaveAbort;
   logic                   next_slaveRespond;
   logic [`BCD_DATA_W-1:0] next_regRdata;
   logic                   wrCmd;
   bcd_code_t              wrCode;
   logic                   accept;
   logic                   cmdStart;
   bcd_len_t               cmdLen;

   function automatic logic bcdHit(input logic [`BCD_ADDR_W-1:0] addr,
                                   input logic [`BCD_ADDR_W-1:0] ofs);
      return addr == ofs;
   endfunction

   // ****************************************
   // Command decode and acceptance
   // ****************************************
   always_comb begin
      wrCmd  = regWr && bcdHit(regAddr, `BCD_OFS_COMMAND);
      // Reserved upper bits are simply not looked at
      // RL2 reserved bits dropped
      wrCode = bcd_code_t'(regWdata[`BCD_CODE_MSB:0]);
      accept = 1'b0;
      cmdLen = bcd_len_t'(EXEC_CYCLES);
      case (wrCode)
         // RL7 no unlock in slave
         BCD_CMD_UNLOCK:      accept = (state != BCD_SLAVE_RX) && (state != BCD_SLAVE_TX);
         // RL8 master request
         BCD_CMD_MASTER:      accept = 1'b1;
         // RL9 master stop gate
         BCD_CMD_STOP_MASTER: begin
            accept = masterRequest || (state == BCD_MASTER);
            cmdLen = bcd_len_t'(STOP_CYCLES);
         end
         // RL11 slave transfer request
         BCD_CMD_SLAVE:       accept = 1'b1;
         // RL12 slave stop gate
         BCD_CMD_STOP_SLAVE: begin
            accept = slaveRequest;
            cmdLen = bcd_len_t'(STOP_CYCLES);
         end
         // RL4 RL5 no action codes
         default:             accept = 1'b0;
      endcase
      // A write while busy is dropped; the running command must finish first
      cmdStart = wrCmd && accept && !cmdExecuting;
   end

   assign ex.start = cmdStart;
   assign ex.code  = wrCode;
   assign ex.len   = cmdLen;

   bcd_cmd_timer u_timer (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .exe     (ex.exe)
   );

   // ****************************************
   // Command field and flags
   // ****************************************
   always_comb begin
      next_cmdField      = BCD_CMD_NOP;
      next_cmdStrobe     = 1'b0;
      next_cmdExecuting  = cmdExecuting;
      next_masterRequest = masterRequest;
      next_slaveRequest  = slaveRequest;
      next_lockActive    = lockActive;
      next_slaveAbort    = 1'b0;
      next_slaveRespond  = 1'b0;
      next_state         = state;

      // RL15 strobe then back to no-op
      if (wrCmd) begin
         next_cmdField  = wrCode;
         next_cmdStrobe = 1'b1;
      end

      // Link side progress
      case (state)
         BCD_WAIT: begin
            if (masterStart && masterRequest) begin
               next_state = BCD_MASTER;
            end else if (slaveSelect) begin
               next_state = BCD_SLAVE_RX;
            end
         end
         BCD_MASTER: begin
            if (masterEnd) begin
               next_state         = BCD_WAIT;
               next_masterRequest = 1'b0;
            end
         end
         BCD_SLAVE_RX: begin
            // RL13 no answer without request
            if (slaveTxReq && slaveRequest) begin
               next_state        = BCD_SLAVE_TX;
               next_slaveRespond = 1'b1;
            end else if (slaveEnd) begin
               next_state = BCD_WAIT;
            end
         end
         BCD_SLAVE_TX: begin
            if (slaveEnd) begin
               next_state        = BCD_WAIT;
               next_slaveRequest = 1'b0;
            end
         end
         default: next_state = BCD_WAIT;
      endcase

      // RL3 executing flag
      if (cmdStart) begin
         next_cmdExecuting = 1'b1;
      end
      if (ex.done) begin
         next_cmdExecuting = 1'b0;
         case (ex.doneCode)
            // RL6 release lock
            BCD_CMD_UNLOCK:      next_lockActive = 1'b0;
            BCD_CMD_MASTER:      next_masterRequest = 1'b1;
            // RL10 stop master to wait
            BCD_CMD_STOP_MASTER: begin
               next_masterRequest = 1'b0;
               // Also catches a master start landing in the same cycle
               if (next_state == BCD_MASTER) begin
                  next_state = BCD_WAIT;
               end
            end
            BCD_CMD_SLAVE:       next_slaveRequest = 1'b1;
            // RL13 RL14 stop slave
            BCD_CMD_STOP_SLAVE: begin
               next_slaveRequest = 1'b0;
               next_slaveRespond = 1'b0;
               if (state == BCD_SLAVE_TX) begin
                  next_state      = BCD_WAIT;
                  next_slaveAbort = 1'b1;
               end else if (next_state == BCD_SLAVE_TX) begin
                  // Request withdrawn before the answer went out
                  next_state = BCD_SLAVE_RX;
               end
            end
            default: next_cmdExecuting = 1'b0;
         endcase
      end

      // A lock from another unit wins over a release in the same cycle
      if (lockSet) begin
         next_lockActive = 1'b1;
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   always_comb begin
      next_regRdata = `BCD_RDATA_RESET;
      // RL1 command reads give zero
      if (regRd && bcdHit(regAddr, `BCD_OFS_FLAGS)) begin
         next_regRdata[`BCD_FLG_CMX]                     = cmdExecuting;
         next_regRdata[`BCD_FLG_MRQ]                     = masterRequest;
         next_regRdata[`BCD_FLG_SRQ]                     = slaveRequest;
         next_regRdata[`BCD_FLG_LOCK]                    = lockActive;
         next_regRdata[`BCD_FLG_ST_MSB:`BCD_FLG_ST_LSB]  = state;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmdField      <= BCD_CMD_NOP;
         cmdStrobe     <= 1'b0;
         cmdExecuting  <= 1'b0;
         masterRequest <= 1'b0;
         slaveRequest  <= 1'b0;
         lockActive    <= 1'b0;
         slaveAbort    <= 1'b0;
         slaveRespond  <= 1'b0;
         state         <= BCD_WAIT;
         regRdata      <= `BCD_RDATA_RESET;
      end else begin
         cmdField      <= next_cmdField;
         cmdStrobe     <= next_cmdStrobe;
         cmdExecuting  <= next_cmdExecuting;
         masterRequest <= next_masterRequest;
         slaveRequest  <= next_slaveRequest;
         lockActive    <= next_lockActive;
         slaveAbort    <= next_slaveAbort;
         slaveRespond  <= next_slaveRespond;
         state         <= next_state;
         regRdata      <= next_regRdata;
      end
   end

   assign cmdCode  = cmdField;
   assign busState = state;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sequence s_longRun;
      cmdExecuting [*4] ##1 !cmdExecuting;
   endsequence

   sequence s_shortRun;
      cmdExecuting ##1 !cmdExecuting;
   endsequence

   property p_strobe;
      wrCmd |=> cmdStrobe && (cmdCode == $past(regWdata[2:0]));
   endproperty
   a_strobe: assert property (p_strobe) else $error("command strobe missing"); // RL15

   property p_field_nop;
      cmdStrobe && !wrCmd |=> !cmdStrobe && (cmdCode == 3'h0);
   endproperty
   a_field_nop: assert property (p_field_nop) else $error("field not back to no-op"); // RL15

   property p_no_action;
      wrCmd && !cmdExecuting && (wrCode inside {BCD_CMD_NOP, BCD_CMD_UNDEF_A, BCD_CMD_UNDEF_B})
         |=> !cmdExecuting;
   endproperty
   a_no_action: assert property (p_no_action) else $error("no-op code started work"); // RL5

   property p_master_run;
      cmdStart && wrCode == BCD_CMD_MASTER |=> s_longRun ##0 masterRequest;
   endproperty
   a_master_run: assert property (p_master_run) else $error("master request timing wrong"); // RL8

   property p_stop_master;
      cmdStart && wrCode == BCD_CMD_STOP_MASTER |=> s_shortRun ##0 (!masterRequest && busState != 2'(BCD_MASTER));
   endproperty
   a_stop_master: assert property (p_stop_master) else $error("master stop not applied"); // RL10

   property p_stop_master_gate;
      wrCmd && wrCode == BCD_CMD_STOP_MASTER && !cmdExecuting && !masterRequest && state != BCD_MASTER
         |=> !cmdExecuting;
   endproperty
   a_stop_master_gate: assert property (p_stop_master_gate) else $error("master stop not ignored"); // RL9

   property p_stop_slave;
      cmdStart && wrCode == BCD_CMD_STOP_SLAVE |=> s_shortRun ##0 !slaveRequest;
   endproperty
   a_stop_slave: assert property (p_stop_slave) else $error("slave stop not applied"); // RL13 RL14

   property p_unlock_slave;
      wrCmd && wrCode == BCD_CMD_UNLOCK && !cmdExecuting && (state == BCD_SLAVE_RX || state == BCD_SLAVE_TX)
         |=> !cmdExecuting;
   endproperty
   a_unlock_slave: assert property (p_unlock_slave) else $error("unlock taken in slave mode"); // RL7

   property p_respond;
      slaveRespond |-> $past(slaveRequest) && busState == 2'(BCD_SLAVE_TX);
   endproperty
   a_respond: assert property (p_respond) else $error("answer without slave request"); // RL13

   property p_abort;
      slaveAbort |-> busState == 2'(BCD_WAIT) && !slaveRequest && $past(state) == BCD_SLAVE_TX;
   endproperty
   a_abort: assert property (p_abort) else $error("abort left wrong state"); // RL14

   property p_read_cmd;
      regRd && bcdHit(regAddr, `BCD_OFS_COMMAND) |=> regRdata == 8'h00;
   endproperty
   a_read_cmd: assert property (p_read_cmd) else $error("command read not zero"); // RL1

endmodule // bcd_bus_command_decoder
`default_nettype wire

//--- core/bcd_cmd_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "bcd_defines.svh"
module bcd_cmd_timer
   import bcd_pkg::*;
(
   input  wire logic   sys_clk,
   input  wire logic   arst_n,
   bcd_exec_if.exe     exe
);
   logic      busy;
   logic      next_busy;
   bcd_len_t  cnt;
   bcd_len_t  next_cnt;
   bcd_code_t code;
   bcd_code_t next_code;

   always_comb begin
      next_busy = busy;
      next_cnt  = cnt;
      next_code = code;
      if (busy) begin
         if (cnt == '0) begin
            next_busy = 1'b0;
         end else begin
            next_cnt = cnt - 1'b1;
         end
      end else if (exe.start) begin
         next_busy = 1'b1;
         next_code = exe.code;
         // A zero length still runs one cycle
         next_cnt  = (exe.len == '0) ? '0 : exe.len - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy <= 1'b0;
         cnt  <= '0;
         code <= BCD_CMD_NOP;
      end else begin
         busy <= next_busy;
         cnt  <= next_cnt;
         code <= next_code;
      end
   end

   assign exe.busy     = busy;
   assign exe.done     = busy && (cnt == '0);
   assign exe.doneCode = code;

   property p_done_ends;
      @(posedge sys_clk) disable iff (!arst_n)
      exe.done |=> !exe.busy;
   endproperty
   a_done_ends: assert property (p_done_ends) else $error("timer stays busy after done"); // RL3

endmodule // bcd_cmd_timer
`default_nettype wire

//--- core/bcd_defines.svh
`ifndef BCD_DEFINES_SVH
`define BCD_DEFINES_SVH

// ****************************************
// Register port geometry
// ****************************************
`define BCD_ADDR_W       4
`define BCD_DATA_W       8
`define BCD_LEN_W        4

// ****************************************
// Register offsets
// ****************************************
`define BCD_OFS_COMMAND  4'h0
`define BCD_OFS_FLAGS    4'h1

// ****************************************
// Field positions and reset values
// ****************************************
`define BCD_CODE_MSB     2
`define BCD_FLG_CMX      0
`define BCD_FLG_MRQ      1
`define BCD_FLG_SRQ      2
`define BCD_FLG_LOCK     3
`define BCD_FLG_ST_LSB   4
`define BCD_FLG_ST_MSB   5
`define BCD_RDATA_RESET  8'h00

// ****************************************
// Timing counts in sys_clk cycles
// ****************************************
`define BCD_EXEC_CYCLES  4
`define BCD_STOP_CYCLES  1

`endif

//--- core/bcd_exec_if.sv
`timescale 1ns/1ns
`default_nettype none
interface bcd_exec_if;
   import bcd_pkg::*;
   logic      start;
   bcd_code_t code;
   bcd_len_t  len;
   logic      busy;
   logic      done;
   bcd_code_t doneCode;

   modport ctl (output start, output code, output len, input busy, input done, input doneCode);
   modport exe (input start, input code, input len, output busy, output done, output doneCode);
endinterface
`default_nettype wire

//--- core/bcd_pkg.sv
`default_nettype none
package bcd_pkg;

   typedef enum logic [2:0] {
      BCD_CMD_NOP         = 3'h0,
      BCD_CMD_UNLOCK      = 3'h1,
      BCD_CMD_MASTER      = 3'h2,
      BCD_CMD_STOP_MASTER = 3'h3,
      BCD_CMD_UNDEF_A     = 3'h4,
      BCD_CMD_SLAVE       = 3'h5,
      BCD_CMD_STOP_SLAVE  = 3'h6,
      BCD_CMD_UNDEF_B     = 3'h7
   } bcd_code_t;

   typedef enum logic [1:0] {
      BCD_WAIT,
      BCD_MASTER,
      BCD_SLAVE_RX,
      BCD_SLAVE_TX
   } bcd_state_t;

   typedef logic [3:0] bcd_len_t;

endpackage
`default_nettype wire

//--- verif/bcd_link_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Link controller stand-in
// ****************************************
// Events idle low and are single-cycle pulses, launched just after an edge
module bcd_link_model (
   input  wire logic sys_clk,
   output wire logic lockSet,
   output wire logic masterStart,
   output wire logic masterEnd,
   output wire logic slaveSelect,
   output wire logic slaveTxReq,
   output wire logic slaveEnd
);
   logic [5:0] act = 6'h00;

   assign {slaveEnd, slaveTxReq, slaveSelect, masterEnd, masterStart, lockSet} = act;

   // Index: 0 lock, 1 master start, 2 master end, 3 select, 4 transmit request, 5 slave end
   task automatic pulse(input int idx);
      @(posedge sys_clk);
      act <= 6'h01 << idx;
      @(posedge sys_clk);
      act <= 6'h00;
      @(negedge sys_clk);
   endtask
endmodule // bcd_link_model
`default_nettype wire

//--- verif/test_bus_command_decoder.sv
`timescale 1ns/1ns
`default_nettype none
`include "bcd_defines.svh"
`define CHK(nm, exp, got) begin cmpCount++; if ((got) !== (exp)) begin nErrors++; $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end
module test_bus_command_decoder
   import bcd_pkg::*;
;
   localparam int P_LOCK = 0;
   localparam int P_MSTART = 1;
   localparam int P_MEND = 2;
   localparam int P_SSEL = 3;
   localparam int P_STX = 4;
   localparam int P_SEND = 5;

   logic                   sys_clk = 1'b0;
   logic                   arst_n;
   logic [`BCD_ADDR_W-1:0] regAddr;
   logic [`BCD_DATA_W-1:0] regWdata;
   logic [`BCD_DATA_W-1:0] regRdata;
   logic                   regWr;
   logic                   regRd;
   logic                   lockSet, masterStart, masterEnd, slaveSelect, slaveTxReq, slaveEnd;
   logic                   cmdStrobe, cmdExecuting, masterRequest, slaveRequest, lockActive;
   logic                   slaveAbort, slaveRespond, abortSeen;
   logic [2:0]             cmdCode;
   logic [1:0]             busState;
   logic [7:0]             rdData;
   logic [2:0]             quiet [3] = '{3'h0, 3'h4, 3'h7};
   int                     nErrors = 0;
   int                     cmpCount = 0;
   int                     cycles = 0;
   int                     execLen;

   always #4 sys_clk = ~sys_clk;

   bcd_bus_command_decoder #(.EXEC_CYCLES(4), .STOP_CYCLES(1)) u_dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .lockSet(lockSet),
      .masterStart(masterStart), .masterEnd(masterEnd), .slaveSelect(slaveSelect),
      .slaveTxReq(slaveTxReq), .slaveEnd(slaveEnd), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode),
      .cmdExecuting(cmdExecuting), .masterRequest(masterRequest), .slaveRequest(slaveRequest),
      .lockActive(lockActive), .slaveAbort(slaveAbort), .slaveRespond(slaveRespond),
      .busState(busState));

   bcd_link_model u_link (
      .sys_clk(sys_clk), .lockSet(lockSet), .masterStart(masterStart), .masterEnd(masterEnd),
      .slaveSelect(slaveSelect), .slaveTxReq(slaveTxReq), .slaveEnd(slaveEnd));

   // ****************************************
   // Register port tasks
   // ****************************************
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
      @(negedge sys_clk);
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      @(negedge sys_clk);
      d = regRdata;
   endtask

   // Writes a command, then follows the busy flag under a bounded wait
   task automatic cmd(input logic [7:0] d, input logic [2:0] code);
      wr(`BCD_OFS_COMMAND, d);
      `CHK("strobe", 1'b1, cmdStrobe)
      `CHK("code", code, cmdCode)
      execLen = 0;
      while (cmdExecuting === 1'b1 && execLen < 20) begin
         execLen++;
         @(negedge sys_clk);
      end
      abortSeen = slaveAbort;
      if (execLen == 0) begin
         @(negedge sys_clk);
      end
      `CHK("strobe end", 1'b0, cmdStrobe)
      `CHK("code end", 3'h0, cmdCode)
   endtask

   // Flags register and the matching outputs, packed alike
   task automatic chk_flags(input logic [7:0] e);
      rd(`BCD_OFS_FLAGS, rdData);
      `CHK("flag reg", e, rdData)
      `CHK("flag outs", e, {2'b00, busState, lockActive, slaveRequest, masterRequest, cmdExecuting})
   endtask

   task automatic complete_run();
      if (nErrors == 0 && cmpCount > 0) begin
         $display("Finished cleanly");
      end
      else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // A hang is cut short well beyond the roughly 140 cycles the sequence needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         nErrors++;
         complete_run();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      regAddr = 4'h0;
      regWdata = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      arst_n = 1'b0;
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(negedge sys_clk);
      `CHK("reset outs", 8'h00, {cmdStrobe, cmdCode, slaveAbort, slaveRespond, busState})
      chk_flags(8'h00);
      rd(`BCD_OFS_COMMAND, rdData);
      `CHK("command read", 8'h00, rdData)
      rd(4'hF, rdData);
      `CHK("unmapped read", 8'h00, rdData)
      foreach (quiet[i]) begin
         cmd(8'hF8 | {5'h00, quiet[i]}, quiet[i]);
         chk_flags(8'h00);
      end
      cmd(8'h03, 3'h3);
      chk_flags(8'h00);
      cmd(8'h06, 3'h6);
      chk_flags(8'h00);
      cmd(8'h02, 3'h2);
      `CHK("exec len", 4, execLen)
      chk_flags(8'h02);
      cmd(8'h03, 3'h3);
      `CHK("stop len", 1, execLen)
      chk_flags(8'h00);
      // Second write lands while the first is still running and must be dropped
      wr(`BCD_OFS_COMMAND, 8'h02);
      cmd(8'h05, 3'h5);
      chk_flags(8'h02);
      u_link.pulse(P_MSTART);
      u_link.pulse(P_LOCK);
      chk_flags(8'h1A);
      cmd(8'h01, 3'h1);
      chk_flags(8'h12);
      cmd(8'h03, 3'h3);
      chk_flags(8'h00);
      cmd(8'h05, 3'h5);
      chk_flags(8'h04);
      u_link.pulse(P_SSEL);
      u_link.pulse(P_LOCK);
      cmd(8'h01, 3'h1);
      chk_flags(8'h2C);
      u_link.pulse(P_STX);
      `CHK("respond", 1'b1, slaveRespond)
      chk_flags(8'h3C);
      cmd(8'h06, 3'h6);
      `CHK("abort", 1'b1, abortSeen)
      chk_flags(8'h08);
      cmd(8'h01, 3'h1);
      chk_flags(8'h00);
      cmd(8'h05, 3'h5);
      cmd(8'h06, 3'h6);
      chk_flags(8'h00);
      u_link.pulse(P_SSEL);
      u_link.pulse(P_STX);
      `CHK("no respond", 1'b0, slaveRespond)
      chk_flags(8'h20);
      u_link.pulse(P_SEND);
      chk_flags(8'h00);
      cmd(8'h02, 3'h2);
      u_link.pulse(P_MSTART);
      u_link.pulse(P_MEND);
      chk_flags(8'h00);
      complete_run();
   end
endmodule // test_bus_command_decoder
`default_nettype wire
